// ==== inc/fifo_cascade_cfg.svh ====
// Offsets, field positions, reset values and sizes of the cascade FIFO
`ifndef FIFO_CASCADE_CFG_SVH
`define FIFO_CASCADE_CFG_SVH

// ***********************
// Storage
// ***********************
`define FC_DATA_W 36
`define FC_ADDR_W 16
`define FC_DEPTH 17'h10000

// ***********************
// Register map
// ***********************
`define FC_REG_STATUS 4'h0
`define FC_REG_INT_STAT 4'h4
`define FC_REG_INT_CLR 4'h8
`define FC_REG_INT_EN 4'hC
`define FC_REG_CTRL 4'h0
`define FC_REG_CTRL_HI 4'h1

// ***********************
// Fields
// ***********************
`define FC_ST_EMPTY 0
`define FC_ST_FULL 1
`define FC_ST_FIRST_WORD_FALL_THROUGH 2
`define FC_ST_VALID 3
`define FC_ST_LVL_LO 8
`define FC_CTRL_ASYNC 0
`define FC_EV_COUNT 4
`define FC_EV_READY 0
`define FC_EV_FULL 1
`define FC_EV_OVER 2
`define FC_EV_UNDER 3

// ***********************
// Reset values
// ***********************
`define FC_INT_EN_RST 4'h0
`define FC_CTRL_RST 1'h0

// ***********************
// Timing
// ***********************
`define FC_LOCK_WAIT 2'h2

`endif

// ==== inc/fifo_cascade_pkg.sv ====
// Types shared by the cascade FIFO
package fifo_cascade_pkg;
	typedef enum logic {MODE_STANDARD, MODE_FIRST_WORD_FALL_THROUGH} mode_type;
endpackage : fifo_cascade_pkg

// ==== rtl/fifo_cascade_expansion.sv ====
// Cascadable 36-bit FIFO with standard and fall-through modes
//
// Notes on behaviour
// - Flag deassertion or ready assertion may differ one cycle between devices.
// - Fall-through holds one word more than standard mode.
// - Asynchronous read works in standard mode only.
// - A chain offers the sum of all device depths.
// - First word ripples to the chain end with no read request.
// - Output ready goes low once a word sits at the outputs.
// - First word reaches the outputs three read cycles after writing.
// - Only the first word into an empty chain sees the latency.
// - A freed location drives input ready low for the upstream device.
`timescale 1ns/1ps
`include "fifo_cascade_cfg.svh"

module fifo_cascade_expansion import fifo_cascade_pkg::*; (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Mode strap, sampled after reset
	input wire logic FIRST_WORD_FALL_THROUGH_SEL,
	// Write side
	input wire logic WEN_N,
	input wire logic [`FC_DATA_W-1:0] WRITE_DATA_BUS,
	output logic FULL_FLAG_N,
	// Read side
	input wire logic REN_N,
	input wire logic ASYNC_RD_N,
	output logic [`FC_DATA_W-1:0] READ_DATA_BUS,
	output logic EMPTY_FLAG_N,
	// Register port
	input wire logic [3:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// Interrupt
	output logic IRQ
);

	// ***********************
	// Declarations
	// ***********************
	logic [`FC_DATA_W-1:0] mem [0:(1<<`FC_ADDR_W)-1];
	logic [`FC_ADDR_W:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	logic [`FC_ADDR_W:0] wr_vis_q, rd_vis_q, wlvl, rlvl;
	logic sel_meta_q, sel_sync_q, mode_lock_q;
	logic ard_meta_q, ard_sync_q, ard_prev_q, ard_pulse;
	mode_type mode_q;
	logic wr_take, rd_inc, mem_empty, async_take, out_take, load;
	logic valid_q, valid_d, empty_n_d, full_n_d;
	logic [`FC_EV_COUNT-1:0] int_stat_q, int_en_q, ev;
	logic async_en_q;
	logic [1:0] lock_cnt_q;
	logic ir_n_d, has_space, avail_now, avail_next;

	function automatic logic [`FC_ADDR_W:0] level_of(
		input logic [`FC_ADDR_W:0] wp,
		input logic [`FC_ADDR_W:0] rp
	);
		level_of = wp - rp;
	endfunction : level_of

	// ***********************
	// Pin synchronisers and mode strap
	// ***********************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sel_meta_q <= 1'h0;
			sel_sync_q <= 1'h0;
			ard_meta_q <= 1'h1;
			ard_sync_q <= 1'h1;
			ard_prev_q <= 1'h1;
		end else begin
			sel_meta_q <= FIRST_WORD_FALL_THROUGH_SEL;
			sel_sync_q <= sel_meta_q;
			ard_meta_q <= ASYNC_RD_N;
			ard_sync_q <= ard_meta_q;
			ard_prev_q <= ard_sync_q;
		end
	end

	assign ard_pulse = ard_prev_q & ~ard_sync_q;

	// Mode is frozen once the strap has crossed both stages
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			lock_cnt_q <= 2'h0;
			mode_lock_q <= 1'h0;
			mode_q <= MODE_STANDARD;
		end else if (!mode_lock_q) begin
			if (lock_cnt_q == `FC_LOCK_WAIT) begin
				mode_lock_q <= 1'h1;
				mode_q <= sel_sync_q ? MODE_FIRST_WORD_FALL_THROUGH : MODE_STANDARD;
			end else begin
				lock_cnt_q <= lock_cnt_q + 2'h1;
			end
		end
	end

	// ***********************
	// Write side
	// ***********************
	assign wlvl = level_of(wr_ptr_q, rd_vis_q);
	assign wr_take = ~WEN_N & mode_lock_q & (wlvl != `FC_DEPTH);
	assign wr_ptr_d = wr_ptr_q + {{`FC_ADDR_W{1'b0}}, wr_take};

	always_ff @(posedge REF_CLK) begin
		if (wr_take) begin
			mem[wr_ptr_q[`FC_ADDR_W-1:0]] <= WRITE_DATA_BUS;
		end
	end

	// One stage of pointer delay models the write/read clock crossing
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wr_ptr_q <= '0;
			wr_vis_q <= '0;
			rd_vis_q <= '0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			wr_vis_q <= wr_ptr_q;
			rd_vis_q <= rd_ptr_q;
		end
	end

	// ***********************
	// Read side
	// ***********************
	assign rlvl = level_of(wr_vis_q, rd_ptr_q);
	assign mem_empty = (rlvl == '0);
	// Async strobe is refused outright in fall-through mode
	assign async_take = ard_pulse & async_en_q & (mode_q == MODE_STANDARD);
	assign out_take = ~REN_N & valid_q;
	// Refill in the same cycle as a read, so no bubble after the first word
	assign load = ~mem_empty & (~valid_q | out_take);

	always_comb begin
		if (mode_q == MODE_FIRST_WORD_FALL_THROUGH) begin
			rd_inc = load;
			valid_d = load | (valid_q & ~out_take);
			empty_n_d = ~valid_d;
		end else begin
			rd_inc = (~REN_N | async_take) & ~mem_empty;
			valid_d = 1'h0;
			empty_n_d = (level_of(wr_ptr_q, rd_ptr_q + {{`FC_ADDR_W{1'b0}},
				rd_inc}) != '0);
		end
		rd_ptr_d = rd_ptr_q + {{`FC_ADDR_W{1'b0}}, rd_inc};
		// Memory plus output word gives one extra word in fall-through
		full_n_d = (level_of(wr_ptr_d, rd_ptr_q) != `FC_DEPTH);
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			rd_ptr_q <= '0;
			valid_q <= 1'h0;
			READ_DATA_BUS <= '0;
		end else begin
			rd_ptr_q <= rd_ptr_d;
			valid_q <= valid_d;
			if (rd_inc) begin
				READ_DATA_BUS <= mem[rd_ptr_q[`FC_ADDR_W-1:0]];
			end
		end
	end

	// Fall-through input ready is low while a word still fits
	assign ir_n_d = (mode_q == MODE_FIRST_WORD_FALL_THROUGH) ? ~full_n_d : full_n_d;

	// Flags drive neighbours directly, so they stay registered
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			EMPTY_FLAG_N <= 1'h0;
			FULL_FLAG_N <= 1'h1;
		end else begin
			EMPTY_FLAG_N <= empty_n_d;
			FULL_FLAG_N <= ir_n_d;
		end
	end

	// ***********************
	// Interrupts
	// ***********************
	// Events in data terms, whatever the pin polarity of the mode
	assign has_space = (mode_q == MODE_FIRST_WORD_FALL_THROUGH) ? ~FULL_FLAG_N : FULL_FLAG_N;
	assign avail_now = (mode_q == MODE_FIRST_WORD_FALL_THROUGH) ? ~EMPTY_FLAG_N : EMPTY_FLAG_N;
	assign avail_next = (mode_q == MODE_FIRST_WORD_FALL_THROUGH) ? ~empty_n_d : empty_n_d;

	always_comb begin
		ev = '0;
		ev[`FC_EV_READY] = ~avail_now & avail_next;
		ev[`FC_EV_FULL] = has_space & ~full_n_d;
		ev[`FC_EV_OVER] = ~WEN_N & (wlvl == `FC_DEPTH);
		ev[`FC_EV_UNDER] = ~REN_N & ((mode_q == MODE_FIRST_WORD_FALL_THROUGH) ? ~valid_q :
			mem_empty);
	end

	// Set wins over a clear in the same cycle
	genvar gi;
	generate
		for (gi = 0; gi < `FC_EV_COUNT; gi++) begin : g_stat
			always_ff @(posedge REF_CLK or posedge RST) begin
				if (RST) begin
					int_stat_q[gi] <= 1'h0;
				end else if (ev[gi]) begin
					int_stat_q[gi] <= 1'h1;
				end else if (REG_WR && REG_ADDR == `FC_REG_INT_CLR &&
					REG_WDATA[gi]) begin
					int_stat_q[gi] <= 1'h0;
				end
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ <= 1'h0;
		end else begin
			IRQ <= |(int_stat_q & int_en_q);
		end
	end

	// ***********************
	// Register port
	// ***********************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			int_en_q <= `FC_INT_EN_RST;
			async_en_q <= `FC_CTRL_RST;
		end else if (REG_WR) begin
			if (REG_ADDR == `FC_REG_INT_EN) begin
				int_en_q <= REG_WDATA[`FC_EV_COUNT-1:0];
			end
			if (REG_ADDR == `FC_REG_CTRL_HI) begin
				async_en_q <= REG_WDATA[`FC_CTRL_ASYNC];
			end
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 32'h0;
		end else begin
			REG_RDATA <= 32'h0;
			if (REG_RD) begin
				unique case (REG_ADDR)
					`FC_REG_STATUS: begin
						REG_RDATA[`FC_ST_EMPTY] <= ~avail_now;
						REG_RDATA[`FC_ST_FULL] <= ~has_space;
						REG_RDATA[`FC_ST_FIRST_WORD_FALL_THROUGH] <= (mode_q == MODE_FIRST_WORD_FALL_THROUGH);
						REG_RDATA[`FC_ST_VALID] <= valid_q;
						REG_RDATA[`FC_ST_LVL_LO+:`FC_ADDR_W+1] <= wlvl;
					end
					`FC_REG_CTRL_HI: REG_RDATA[`FC_CTRL_ASYNC] <= async_en_q;
					`FC_REG_INT_STAT: REG_RDATA[`FC_EV_COUNT-1:0] <= int_stat_q;
					`FC_REG_INT_EN: REG_RDATA[`FC_EV_COUNT-1:0] <= int_en_q;
					default: REG_RDATA <= 32'h0;
				endcase
			end
		end
	end

	// ***********************
	// Checks
	// ***********************
	property p_std_empty_clears;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_STANDARD && wr_take && !EMPTY_FLAG_N)
			|-> ##[1:3] EMPTY_FLAG_N;
	endproperty
	a_std_empty_clears: assert property (p_std_empty_clears)
		else $error("empty flag did not clear after write");

	property p_first_word_fall_through_full_level;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && $rose(FULL_FLAG_N))
			|-> $past(wlvl) == `FC_DEPTH - 17'h1 || wlvl == `FC_DEPTH;
	endproperty
	a_first_word_fall_through_full_level: assert property (p_first_word_fall_through_full_level)
		else $error("fall-through full flag at wrong level");

	property p_async_refused;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && ard_pulse && REN_N && valid_q)
			|=> $stable(READ_DATA_BUS) && valid_q;
	endproperty
	a_async_refused: assert property (p_async_refused)
		else $error("async read taken in fall-through mode");

	property p_std_full_level;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_STANDARD && !FULL_FLAG_N) |-> wlvl == `FC_DEPTH;
	endproperty
	a_std_full_level: assert property (p_std_full_level)
		else $error("full flag low below depth");

	property p_ready_tracks_word;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && !valid_q && load)
			|=> !EMPTY_FLAG_N && valid_q;
	endproperty
	a_ready_tracks_word: assert property (p_ready_tracks_word)
		else $error("output ready not low with word present");

	property p_first_word_latency;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && wr_take && wlvl == '0 && rlvl == '0 &&
			!valid_q && EMPTY_FLAG_N) |-> ##3 !EMPTY_FLAG_N;
	endproperty
	a_first_word_latency: assert property (p_first_word_latency)
		else $error("first word latency not three cycles");

	property p_no_bubble;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && out_take && !mem_empty)
			|=> valid_q && !EMPTY_FLAG_N;
	endproperty
	a_no_bubble: assert property (p_no_bubble)
		else $error("gap after first word");

	property p_space_frees;
		@(posedge REF_CLK) disable iff (RST)
		(mode_q == MODE_FIRST_WORD_FALL_THROUGH && FULL_FLAG_N && out_take && WEN_N)
			|-> ##[1:4] !FULL_FLAG_N;
	endproperty
	a_space_frees: assert property (p_space_frees)
		else $error("input ready stuck after read");

	property p_mode_from_strap;
		@(posedge REF_CLK) disable iff (RST)
		$rose(mode_lock_q) |-> (mode_q == MODE_FIRST_WORD_FALL_THROUGH) == $past(sel_sync_q);
	endproperty
	a_mode_from_strap: assert property (p_mode_from_strap)
		else $error("mode not taken from strap");

endmodule : fifo_cascade_expansion

// ==== verification/fifo_cascade_expansion_bench.sv ====
// Self-checking bench for the cascade FIFO
`timescale 1ns/1ps
`include "fifo_cascade_cfg.svh"

module fifo_cascade_expansion_bench import fifo_cascade_pkg::*;;
	// ****
	// Signals
	// ****
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic wen_n = 1'b1;
	logic async_n = 1'b1;
	logic stall = 1'b1;
	logic poke_n = 1'b1;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [3:0] raddr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic [`FC_DATA_W-1:0] wdata = '0;
	logic [`FC_DATA_W-1:0] rdata;
	logic [31:0] reg_rdata;
	logic full_n, empty_n, irq, ren_n, part_ren_n;
	logic [16:0] taken;
	logic first_word_fall_through_sel = 1'b1;
	logic full_hi_n, empty_hi_n, comp_or_n, comp_ir_n, comp_ef_n, comp_ff_n;
	logic [`FC_DATA_W-1:0] rdata_hi, exp_w;
	logic [`FC_DATA_W-1:0] exp_q[$];
	int miscompares = 0;
	int checks_done = 0;

	always #20 ref_clk = ~ref_clk;
	assign ren_n = part_ren_n & poke_n;
	// Merged flags go through gates, never wired together
	assign comp_or_n = empty_n | empty_hi_n;
	assign comp_ir_n = full_n | full_hi_n;
	assign comp_ef_n = empty_n & empty_hi_n;
	assign comp_ff_n = full_n & full_hi_n;

	fifo_cascade_expansion DUT (.REF_CLK(ref_clk), .RST(rst),
		.FIRST_WORD_FALL_THROUGH_SEL(first_word_fall_through_sel), .WEN_N(wen_n), .WRITE_DATA_BUS(wdata),
		.FULL_FLAG_N(full_n), .REN_N(ren_n), .ASYNC_RD_N(async_n),
		.READ_DATA_BUS(rdata), .EMPTY_FLAG_N(empty_n), .REG_ADDR(raddr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .IRQ(irq));
	// Side by side twin: same depth, all controls shared
	fifo_cascade_expansion DUT_HI (.REF_CLK(ref_clk), .RST(rst),
		.FIRST_WORD_FALL_THROUGH_SEL(first_word_fall_through_sel), .WEN_N(wen_n),
		.WRITE_DATA_BUS(~wdata), .FULL_FLAG_N(full_hi_n), .REN_N(ren_n),
		.ASYNC_RD_N(async_n), .READ_DATA_BUS(rdata_hi),
		.EMPTY_FLAG_N(empty_hi_n), .REG_ADDR(raddr), .REG_WDATA(reg_wdata),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(), .IRQ());
	fifo_stream_reader reader (.clk(ref_clk), .rst(rst),
		.word_present(~comp_or_n), .take_n(part_ren_n), .stall(stall),
		.taken_q(taken));

	// ****
	// Tasks
	// ****
	task automatic chk(input string what, input logic [35:0] e,
		input logic [35:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, s);
		end
	endtask : chk
	task automatic wrap_up;
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : wrap_up
	task automatic reg_w(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		raddr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : reg_w
	task automatic reg_r(input logic [3:0] a, input logic [31:0] e,
		input string what);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		raddr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, 36'(e), 36'(reg_rdata));
	endtask : reg_r
	// Back-to-back writes; random or index data
	task automatic push(input int n, input bit rnd_on);
		logic [63:0] d;
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			d = rnd_on ? {$urandom, $urandom} : 64'(i);
			wen_n <= 1'b0;
			wdata <= d[35:0];
			exp_q.push_back(d[35:0]);
		end
		@(posedge ref_clk);
		wen_n <= 1'b1;
	endtask : push
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// ****
	// Read order check
	// ****
	always @(posedge ref_clk) begin
		if (!rst && !ren_n && comp_or_n === 1'b0) begin
			exp_w = exp_q.size() ? exp_q.pop_front() : 'x;
			chk("word", exp_w, rdata);
			chk("upper word", ~exp_w, rdata_hi);
		end
	end

	// ****
	// Sequence
	// ****
	initial begin
		repeat (90000) @(posedge ref_clk);
		miscompares++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hCCB37F7E));
		repeat (12) @(posedge ref_clk);
		#1;
		chk("reset flags", 36'h2, 36'({irq, full_n, empty_n}));
		@(posedge ref_clk);
		rst <= 1'b0;
		cyc(4);
		reg_r(`FC_REG_STATUS, 32'h5, "status");
		reg_r(4'h2, 32'h0, "unmapped");
		reg_w(`FC_REG_INT_EN, 32'hF);
		reg_r(`FC_REG_INT_EN, 32'hF, "int enable");
		reg_w(`FC_REG_CTRL_HI, 32'h1);
		reg_r(`FC_REG_CTRL_HI, 32'h1, "ctrl");
		push(1, 1'b1);
		cyc(1);
		chk("ready early", 36'h1, 36'(comp_or_n));
		cyc(1);
		chk("ready", 36'h0, 36'(comp_or_n));
		chk("first word", exp_q[0], rdata);
		chk("first upper", ~exp_q[0], rdata_hi);
		// Strobe must not consume in fall-through
		@(posedge ref_clk);
		async_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		async_n <= 1'b1;
		cyc(4);
		chk("async kept", exp_q[0], rdata);
		chk("async taken", 36'h1, 36'(exp_q.size()));
		@(posedge ref_clk);
		stall <= 1'b0;
		push(8, 1'b1);
		cyc(5);
		chk("drained", 36'h0, 36'(exp_q.size()));
		chk("taken", 36'h9, 36'(taken));
		reg_w(`FC_REG_INT_CLR, 32'hF);
		reg_r(`FC_REG_INT_STAT, 32'h0, "stat clear");
		@(posedge ref_clk);
		poke_n <= 1'b0;
		@(posedge ref_clk);
		poke_n <= 1'b1;
		reg_r(`FC_REG_INT_STAT, 32'h8, "underflow");
		chk("irq", 36'h1, 36'(irq));
		reg_w(`FC_REG_INT_EN, 32'h0);
		cyc(2);
		chk("irq masked", 36'h0, 36'(irq));
		reg_w(`FC_REG_INT_CLR, 32'h8);
		reg_w(`FC_REG_INT_EN, 32'hF);
		cyc(2);
		chk("irq cleared", 36'h0, 36'(irq));
		// Fill to the fall-through capacity
		@(posedge ref_clk);
		stall <= 1'b1;
		push(65536, 1'b0);
		cyc(4);
		chk("not yet full", 36'h0, 36'(comp_ir_n));
		push(1, 1'b0);
		#1;
		chk("full", 36'h1, 36'(comp_ir_n));
		@(posedge ref_clk);
		wen_n <= 1'b0;
		@(posedge ref_clk);
		wen_n <= 1'b1;
		reg_r(`FC_REG_INT_STAT, 32'h7, "full events");
		@(posedge ref_clk);
		stall <= 1'b0;
		@(posedge ref_clk);
		stall <= 1'b1;
		for (int i = 0; i < 8 && comp_ir_n !== 1'b0; i++) begin
			@(posedge ref_clk);
		end
		chk("space freed", 36'h0, 36'(comp_ir_n));
		// Standard mode behind a second reset
		@(posedge ref_clk);
		rst <= 1'b1;
		first_word_fall_through_sel <= 1'b0;
		exp_q.delete();
		cyc(2);
		@(posedge ref_clk);
		rst <= 1'b0;
		cyc(4);
		reg_r(`FC_REG_STATUS, 32'h1, "std status");
		chk("std full", 36'h1, 36'(comp_ff_n));
		push(2, 1'b1);
		cyc(1);
		chk("std not empty", 36'h1, 36'(comp_ef_n));
		@(posedge ref_clk);
		poke_n <= 1'b0;
		@(posedge ref_clk);
		poke_n <= 1'b1;
		#1;
		chk("std word", exp_q[0], rdata);
		chk("std upper", ~exp_q[0], rdata_hi);
		void'(exp_q.pop_front());
		reg_w(`FC_REG_CTRL_HI, 32'h1);
		@(posedge ref_clk);
		async_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		async_n <= 1'b1;
		cyc(4);
		chk("async word", exp_q[0], rdata);
		chk("async upper", ~exp_q[0], rdata_hi);
		chk("std empty", 36'h0, 36'(comp_ef_n));
		wrap_up();
	end
endmodule : fifo_cascade_expansion_bench

// ==== verification/fifo_stream_reader.sv ====
// Downstream reader model for the cascade FIFO
`timescale 1ns/1ps

module fifo_stream_reader (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Device read side
	input wire logic word_present,
	output logic take_n,
	// Bench control
	input wire logic stall,
	output logic [16:0] taken_q
);
	// ****
	// Take
	// ****
	// Combinational take: no bubble between words
	assign take_n = ~(word_present & ~stall);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			taken_q <= 17'h0;
		end else if (!take_n) begin
			taken_q <= taken_q + 17'h1;
		end
	end
endmodule : fifo_stream_reader
